// ---- hw/np_tx_pkg.sv ----
// package for the next page transmit register block
// assumes a 16-bit management word path and a single 100 mhz clock
package np_tx_pkg;
    localparam int unsigned REG_WIDTH = 16;
    localparam logic [4:0] NEXT_PAGE_TX_OFFSET = 5'h08;
    localparam int unsigned MORE_PAGES_POS = 15;
    localparam int unsigned RESERVED_POS = 14;
    localparam int unsigned MESSAGE_FORMAT_POS = 13;
    localparam int unsigned SECOND_ACK_POS = 12;
    localparam int unsigned TOGGLE_POS = 11;
    localparam int unsigned CODE_MSB = 10;
    localparam int unsigned BASE_TOGGLE_POS = 11;
    localparam logic [15:0] NEXT_PAGE_TX_RESET = 16'h0000;
    localparam logic [15:0] WRITABLE_MASK = 16'hb7ff;
endpackage

// ---- hw/np_toggle_track.sv ----
// toggle tracker for outgoing next page words
// assumes page_sent pulses once per transmitted next page word
`timescale 1ns/1ps
module np_toggle_track
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic base_page_toggle_src,
    input wire logic base_page_sent,
    input wire logic page_sent,
    output logic toggle_bit
);
    logic toggle_reg;

    // ---------------------------------------------
    // toggle state
    // ---------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            toggle_reg <= 1'b0;
        else if (base_page_sent)
            toggle_reg <= ~base_page_toggle_src;
        else if (page_sent)
            toggle_reg <= ~toggle_reg;
    end

    assign toggle_bit = toggle_reg;

    a_toggle_flip: assert property (@(posedge clock)
        disable iff (sys_rst)
        page_sent && !base_page_sent |=> toggle_reg != $past(toggle_reg))
        else $error("toggle did not invert");
    a_toggle_first: assert property (@(posedge clock)
        disable iff (sys_rst)
        base_page_sent |=> toggle_reg == !$past(base_page_toggle_src))
        else $error("first toggle wrong");
endmodule // np_toggle_track

// ---- hw/next_page_tx.sv ----
// next page transmit register and outgoing next page word
// assumes a management engine presenting 16-bit reads and writes,
// and an autoneg engine that pulses when it sends base and next pages
`timescale 1ns/1ps

module next_page_tx
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mgmt_write,
    input wire logic mgmt_read,
    input wire logic [4:0] mgmt_addr,
    input wire logic [np_tx_pkg::REG_WIDTH-1:0] mgmt_wdata,
    output logic [np_tx_pkg::REG_WIDTH-1:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic [np_tx_pkg::REG_WIDTH-1:0] base_page_word,
    input wire logic base_page_sent,
    input wire logic partner_np_able,
    input wire logic page_sent,
    output logic [np_tx_pkg::REG_WIDTH-1:0] np_word,
    output logic np_enable,
    output logic more_pages_flag
);
    import np_tx_pkg::*;

    logic [REG_WIDTH-1:0] next_page_transmit_reg;
    logic [REG_WIDTH-1:0] next_page_transmit_next;
    logic toggle_bit;
    logic hit;

    // ---------------------------------------------
    // word assembly
    // ---------------------------------------------
    // read-back and the word check share it, so they cannot disagree
    function automatic logic [REG_WIDTH-1:0] compose_word(
        input logic [REG_WIDTH-1:0] stored,
        input logic toggle
    );
        logic [REG_WIDTH-1:0] w;
        w = stored;
        w[RESERVED_POS] = 1'b0;
        w[TOGGLE_POS] = toggle;
        return w;
    endfunction

    // ---------------------------------------------
    // register store
    // ---------------------------------------------
    // the station keeps bit 14 at default; we drop it anyway
    assign hit = (mgmt_addr == NEXT_PAGE_TX_OFFSET);
    assign next_page_transmit_next = mgmt_wdata & WRITABLE_MASK;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            next_page_transmit_reg <= NEXT_PAGE_TX_RESET;
        else if (mgmt_write && hit)
            next_page_transmit_reg <= next_page_transmit_next;
    end

    // ---------------------------------------------
    // read path
    // ---------------------------------------------
    // toggle is device owned, so it reads back live
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end
        else
        begin
            mgmt_rvalid <= mgmt_read;
            if (mgmt_read)
            begin
                if (hit)
                begin
                    mgmt_rdata <= compose_word(next_page_transmit_reg,
                        toggle_bit);
                end
                else
                    mgmt_rdata <= 16'h0000;
            end
        end
    end

    // ---------------------------------------------
    // toggle
    // ---------------------------------------------
    np_toggle_track u_toggle
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .base_page_toggle_src(base_page_word[BASE_TOGGLE_POS]),
        .base_page_sent(base_page_sent),
        .page_sent(page_sent),
        .toggle_bit(toggle_bit)
    );

    // ---------------------------------------------
    // outgoing word
    // ---------------------------------------------
    // registered so the word follows the register and toggle one cycle later
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            np_word <= 16'h0000;
            np_enable <= 1'b0;
            more_pages_flag <= 1'b0;
        end
        else
        begin
            np_word[MORE_PAGES_POS] <=
                next_page_transmit_reg[MORE_PAGES_POS];
            np_word[RESERVED_POS] <= 1'b0;
            np_word[MESSAGE_FORMAT_POS] <=
                next_page_transmit_reg[MESSAGE_FORMAT_POS];
            np_word[SECOND_ACK_POS] <=
                next_page_transmit_reg[SECOND_ACK_POS];
            np_word[TOGGLE_POS] <= toggle_bit;
            np_word[CODE_MSB:0] <=
                next_page_transmit_reg[CODE_MSB:0];
            more_pages_flag <= next_page_transmit_reg[MORE_PAGES_POS];
            np_enable <= next_page_transmit_reg[MORE_PAGES_POS]
                && partner_np_able;
        end
    end

    // ---------------------------------------------
    // register checks
    // ---------------------------------------------
    a_rsvd_zero: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_rvalid |-> mgmt_rdata[RESERVED_POS] == 1'b0)
        else $error("reserved bit read as one");
    a_rvalid_pulse: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_rvalid == $past(mgmt_read))
        else $error("read valid not one cycle after read");
    a_rdata_hold: assert property (@(posedge clock)
        disable iff (sys_rst)
        !$past(mgmt_read) |-> $stable(mgmt_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_rvalid && !$past(hit) |-> mgmt_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_toggle_read: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_rvalid && $past(hit)
            |-> mgmt_rdata[TOGGLE_POS] == $past(toggle_bit))
        else $error("toggle read back wrong");
    a_write_store: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_write && hit |=> next_page_transmit_reg
            == ($past(mgmt_wdata) & WRITABLE_MASK))
        else $error("write not stored");
    a_hold_value: assert property (@(posedge clock)
        disable iff (sys_rst)
        !(mgmt_write && hit) |=> $stable(next_page_transmit_reg))
        else $error("register changed without write");

    // ---------------------------------------------
    // link word checks
    // ---------------------------------------------
    a_np_tracks: assert property (@(posedge clock)
        disable iff (sys_rst)
        np_word[MORE_PAGES_POS] == $past(next_page_transmit_reg[15]))
        else $error("np flag mismatch");
    a_word_fields: assert property (@(posedge clock)
        disable iff (sys_rst)
        np_word == compose_word($past(next_page_transmit_reg),
            $past(toggle_bit)))
        else $error("link word differs from register");
    a_np_toggle: assert property (@(posedge clock)
        disable iff (sys_rst)
        np_word[TOGGLE_POS] == $past(toggle_bit))
        else $error("link toggle wrong");
    a_np_gate: assert property (@(posedge clock)
        disable iff (sys_rst)
        np_enable |-> $past(partner_np_able)
            && $past(next_page_transmit_reg[MORE_PAGES_POS]))
        else $error("next page sent without partner");
    a_enable_on: assert property (@(posedge clock)
        disable iff (sys_rst)
        partner_np_able && next_page_transmit_reg[MORE_PAGES_POS]
            |=> np_enable)
        else $error("next pages not enabled");
    a_enable_off: assert property (@(posedge clock)
        disable iff (sys_rst)
        !partner_np_able |=> !np_enable)
        else $error("enabled without partner ability");
    a_last_flag: assert property (@(posedge clock)
        disable iff (sys_rst)
        more_pages_flag == $past(next_page_transmit_reg[MORE_PAGES_POS]))
        else $error("more pages flag wrong");
    a_mp_follow: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_write && hit |=> ##1 np_word[13] == $past(mgmt_wdata[13], 2))
        else $error("message flag not carried");
    a_ack_follow: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_write && hit |=> ##1 np_word[12] == $past(mgmt_wdata[12], 2))
        else $error("ack flag not carried");
    a_code_follow: assert property (@(posedge clock)
        disable iff (sys_rst)
        mgmt_write && hit |=> ##1 np_word[10:0] == $past(mgmt_wdata[10:0], 2))
        else $error("code field not carried");

    // ---------------------------------------------
    // coverage
    // ---------------------------------------------
    c_write: cover property (@(posedge clock) mgmt_write && hit);
    c_read: cover property (@(posedge clock) mgmt_read && hit);
    c_enable: cover property (@(posedge clock) np_enable);
    c_pages: cover property (@(posedge clock) page_sent && np_enable);
endmodule // next_page_tx

// ---- testbench/np_link_partner.sv ----
// far-side model: autoneg page events and partner next page ability
// assumes the bench calls its tasks; it drives on falling edges only
`timescale 1ns/1ps
module np_link_partner
(
    input wire logic clock,
    output logic [15:0] base_page_word,
    output logic base_page_sent,
    output logic page_sent,
    output logic partner_np_able
);
    initial
    begin
        base_page_word = 16'h0000;
        base_page_sent = 1'b0;
        page_sent = 1'b0;
        partner_np_able = 1'b0;
    end
    task automatic send_base(input logic [15:0] w);
        @(negedge clock);
        base_page_word = w;
        base_page_sent = 1'b1;
        @(negedge clock);
        base_page_sent = 1'b0;
    endtask
    task automatic send_page();
        @(negedge clock);
        page_sent = 1'b1;
        @(negedge clock);
        page_sent = 1'b0;
    endtask
    // level only; next pages flow only while it is high
    task automatic set_able(input logic v);
        @(negedge clock);
        partner_np_able = v;
    endtask
endmodule // np_link_partner

// ---- testbench/next_page_tx_bench.sv ----
// self-checking bench for the next page transmit register
// assumes the link partner model drives the page events
`timescale 1ns/1ps
module next_page_tx_bench;
    import np_tx_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic mgmt_write = 1'b0;
    logic mgmt_read = 1'b0;
    logic [4:0] mgmt_addr = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic [15:0] mgmt_rdata, np_word, base_page_word, d, r;
    logic mgmt_rvalid, np_enable, more_pages_flag;
    logic base_page_sent, page_sent, partner_np_able;
    logic [15:0] reg_model = 16'h0000;
    logic tog = 1'b0;
    int err_total = 0;
    int comparisons = 0;
    int seed = 87763;
    always #5 clock = ~clock;
    np_link_partner link_u (.clock, .base_page_word, .base_page_sent,
        .page_sent, .partner_np_able);
    next_page_tx dut_u (.clock, .sys_rst, .mgmt_write, .mgmt_read,
        .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid,
        .base_page_word, .base_page_sent, .partner_np_able, .page_sent,
        .np_word, .np_enable, .more_pages_flag);
    // ----------------------------------------
    // expectation and compare helpers
    // ----------------------------------------
    function automatic logic [15:0] shown(input logic [15:0] v, input logic t);
        return {v[15], 1'b0, v[13:12], t, v[10:0]};
    endfunction
    task automatic fail(input string m);
        err_total++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] e);
        comparisons++;
        if (got !== e) fail("word mismatch");
    endtask
    task automatic chk_bit(input logic got, input logic e);
        comparisons++;
        if (got !== e) fail("flag mismatch");
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge clock);
        mgmt_write = 1'b1;
        mgmt_addr = a;
        mgmt_wdata = v;
        @(negedge clock);
        mgmt_write = 1'b0;
        if (a == NEXT_PAGE_TX_OFFSET) reg_model = v & WRITABLE_MASK;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(negedge clock);
        mgmt_read = 1'b1;
        mgmt_addr = a;
        @(negedge clock);
        mgmt_read = 1'b0;
        chk_bit(mgmt_rvalid, 1'b1);
        chk_word(mgmt_rdata, e);
        @(negedge clock);
        chk_bit(mgmt_rvalid, 1'b0);
        chk_word(mgmt_rdata, e);
    endtask
    task automatic look();
        repeat (2) @(negedge clock);
        chk_word(np_word, shown(reg_model, tog));
        chk_bit(np_enable, reg_model[15] & partner_np_able);
        chk_bit(more_pages_flag, reg_model[15]);
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        rd(NEXT_PAGE_TX_OFFSET, 16'h0000);
        for (int i = 0; i < 30; i++)
        begin
            d = 16'($random(seed));
            r = 16'($random(seed));
            d[14] = 1'b0;
            if (i == 0) d = 16'hb7ff;
            if (r[0]) link_u.set_able(r[1]);
            if (r[2])
            begin
                link_u.send_base(r);
                tog = ~r[11];
            end
            wr(NEXT_PAGE_TX_OFFSET, d);
            look();
            rd(NEXT_PAGE_TX_OFFSET, shown(reg_model, tog));
            // unmapped place must not store, and must read back as zero
            wr(5'h09, ~d);
            rd(5'h09, 16'h0000);
            if (r[3])
            begin
                link_u.send_page();
                tog = ~tog;
            end
            look();
        end
        // mid-run reset clears the word and the toggle
        @(negedge clock);
        sys_rst = 1'b1;
        @(negedge clock);
        sys_rst = 1'b0;
        reg_model = 16'h0000;
        tog = 1'b0;
        look();
        finish_test();
    end
    initial
    begin
        #100000;
        fail("timeout");
        finish_test();
    end
endmodule // next_page_tx_bench
